// *** shared/abe_pkg.sv ***
/*
 Constants, types and helpers shared by the accumulator, logic and bit-operation executor.
 Assumes one clock, a synchronous active-low reset and an Avalon-MM master that issues one access at a time.
*/
package abe_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [9:0] ABE_OFF_INSTR = 10'h000;
   localparam logic [9:0] ABE_OFF_ACC = 10'h004;
   localparam logic [9:0] ABE_OFF_FLAGS = 10'h008;
   localparam logic [9:0] ABE_OFF_CYCLES = 10'h00C;
   localparam int ABE_FILE_SEL_BIT = 9;
   localparam logic [6:0] ABE_PORT_ADDR = 7'h06;

   localparam int ABE_FLG_C = 0;
   localparam int ABE_FLG_DC = 1;
   localparam int ABE_FLG_Z = 2;
   localparam int ABE_FLG_SKIP = 3;

   localparam int ABE_OP_LSB = 10;
   localparam int ABE_D_BIT = 7;
   localparam int ABE_B_LSB = 7;

   localparam logic [3:0] ABE_OP_NOP = 4'h0;
   localparam logic [3:0] ABE_OP_ADD_LIT = 4'h1;
   localparam logic [3:0] ABE_OP_ADD_FILE = 4'h2;
   localparam logic [3:0] ABE_OP_AND_LIT = 4'h3;
   localparam logic [3:0] ABE_OP_AND_FILE = 4'h4;
   localparam logic [3:0] ABE_OP_CLR_BIT = 4'h5;
   localparam logic [3:0] ABE_OP_SET_BIT = 4'h6;
   localparam logic [3:0] ABE_OP_TEST_SKIP = 4'h7;

   localparam logic [7:0] ABE_ACC_RST = 8'h00;
   localparam logic [7:0] ABE_PORT_RST = 8'h00;
   localparam logic [13:0] ABE_INSTR_RST = 14'h0000;
   localparam logic [15:0] ABE_CYCLES_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ABE_IDLE = 3'b001,
      ABE_EXEC = 3'b010,
      ABE_RESP = 3'b100
   } abe_state_t;

   typedef struct packed {
      logic [9:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } abe_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } abe_avm_rsp_t;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic dc;
      logic z;
   } abe_alu_out_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } abe_fwr_t;

   typedef struct packed {
      abe_state_t st;
      logic [13:0] instr;
      logic [7:0] acc;
      logic c;
      logic dc;
      logic z;
      logic skip;
      logic [15:0] cycles;
      logic [31:0] rdata;
   } abe_core_st_t;

   localparam abe_core_st_t ABE_CORE_RST = '{
      st: ABE_IDLE, instr: ABE_INSTR_RST, acc: ABE_ACC_RST, c: 1'b0, dc: 1'b0, z: 1'b0,
      skip: 1'b0, cycles: ABE_CYCLES_RST, rdata: 32'h00000000};

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge of a bus write into an existing word
   function automatic logic [31:0] abe_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   function automatic logic abe_is_file(input logic [9:0] a);
      return a[ABE_FILE_SEL_BIT] && (a[1:0] == 2'h0);
   endfunction

endpackage

// *** test/tb_acc_logic_bit_op_exec.sv ***
/*
 Self-checking bench for the add, AND and bit-operation executor, driven through its Avalon-MM slave.
 Assumes abe_pkg and abe_core are compiled first; the bench itself plays the bus master and the port pins.
*/
`timescale 1ns/1ns
module tb_acc_logic_bit_op_exec;
   import abe_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   abe_avm_req_t avm_req = '0;
   abe_avm_rsp_t avm_rsp;
   logic [7:0] pins_in = 8'h00;
   logic [7:0] port_out;
   int n_errors = 0;
   int check_count = 0;

   always #20 clk_sys = ~clk_sys;

   abe_core i_dut (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .avm_req(avm_req),
      .avm_rsp(avm_rsp),
      .pins_in(pins_in),
      .port_out(port_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request launches after an edge and is judged only at rising edges; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      logic [31:0] waits;
      waits = 32'h0;
      @(posedge clk_sys);
      avm_req.address <= addr;
      avm_req.read <= ~wr;
      avm_req.write <= wr;
      avm_req.writedata <= wd;
      avm_req.byteenable <= be;
      @(posedge clk_sys);
      while (avm_rsp.waitrequest !== 1'b0) begin
         waits = waits + 32'h1;
         @(posedge clk_sys);
      end
      // One wait cycle for a plain access, two while an instruction executes
      chk(waits, (wr && addr == ABE_OFF_INSTR) ? 32'h2 : 32'h1);
      rd = avm_rsp.readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
   endtask

   task automatic wr_reg(input logic [9:0] addr, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, addr, d, 4'hF, x);
   endtask

   task automatic rd_chk(input logic [9:0] addr, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, addr, 32'h0, 4'hF, x);
      chk(x, exp);
   endtask

   task automatic exec(input logic [3:0] op, input logic [9:0] arg);
      wr_reg(ABE_OFF_INSTR, {18'h0, op, arg});
   endtask

   function automatic logic [9:0] fa(input logic [6:0] f);
      return 10'h200 + {1'b0, f, 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(ABE_OFF_ACC, 32'h0);
      rd_chk(ABE_OFF_FLAGS, 32'h0);
      rd_chk(ABE_OFF_CYCLES, 32'h0);
      chk({24'h0, port_out}, 32'h0);
      rd_chk(10'h100, 32'h0);
   endtask

   task automatic t_lanes();
      logic [31:0] x;
      wr_reg(ABE_OFF_ACC, 32'h33);
      bus(1'b1, ABE_OFF_ACC, 32'hCC, 4'hE, x);
      rd_chk(ABE_OFF_ACC, 32'h33);
      bus(1'b1, ABE_OFF_ACC, 32'h0000CC00, 4'h3, x);
      rd_chk(ABE_OFF_ACC, 32'h00);
   endtask

   task automatic t_mid_reset();
      wr_reg(ABE_OFF_ACC, 32'h55);
      wr_reg(ABE_OFF_FLAGS, 32'h7);
      wr_reg(fa(ABE_PORT_ADDR), 32'hA5);
      @(posedge clk_sys);
      chk({24'h0, port_out}, 32'hA5);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      chk({24'h0, port_out}, 32'h0);
      rd_chk(ABE_OFF_ACC, 32'h0);
      rd_chk(ABE_OFF_FLAGS, 32'h0);
      rd_chk(ABE_OFF_CYCLES, 32'h0);
   endtask

   task automatic t_add_lit();
      logic [7:0] a [4] = '{8'h0F, 8'hFF, 8'h7F, 8'h00};
      logic [7:0] k [4] = '{8'h01, 8'h01, 8'h7F, 8'h00};
      logic [8:0] s;
      logic dc;
      for (int i = 0; i < 4; i++) begin
         s = {1'b0, a[i]} + {1'b0, k[i]};
         dc = ({1'b0, a[i][3:0]} + {1'b0, k[i][3:0]}) > 5'h0F;
         wr_reg(ABE_OFF_ACC, {24'h0, a[i]});
         exec(ABE_OP_ADD_LIT, {2'b00, k[i]});
         rd_chk(ABE_OFF_ACC, {24'h0, s[7:0]});
         rd_chk(ABE_OFF_FLAGS, {29'h0, s[7:0] == 8'h00, dc, s[8]});
      end
   endtask

   task automatic t_add_file();
      wr_reg(fa(7'h10), 32'h88);
      wr_reg(ABE_OFF_ACC, 32'h78);
      exec(ABE_OP_ADD_FILE, 10'h010);
      rd_chk(ABE_OFF_ACC, 32'h00);
      rd_chk(ABE_OFF_FLAGS, 32'h7);
      rd_chk(fa(7'h10), 32'h88);
      wr_reg(ABE_OFF_ACC, 32'h01);
      exec(ABE_OP_ADD_FILE, 10'h090);
      rd_chk(fa(7'h10), 32'h89);
      rd_chk(ABE_OFF_ACC, 32'h01);
      rd_chk(ABE_OFF_FLAGS, 32'h0);
   endtask

   task automatic t_and();
      wr_reg(ABE_OFF_FLAGS, 32'h3);
      wr_reg(ABE_OFF_ACC, 32'hF0);
      exec(ABE_OP_AND_LIT, 10'h00F);
      rd_chk(ABE_OFF_ACC, 32'h00);
      rd_chk(ABE_OFF_FLAGS, 32'h7);
      wr_reg(fa(7'h11), 32'h3C);
      wr_reg(ABE_OFF_ACC, 32'h0F);
      exec(ABE_OP_AND_FILE, 10'h091);
      rd_chk(fa(7'h11), 32'h0C);
      rd_chk(ABE_OFF_ACC, 32'h0F);
      rd_chk(ABE_OFF_FLAGS, 32'h3);
      exec(ABE_OP_AND_FILE, 10'h011);
      rd_chk(ABE_OFF_ACC, 32'h0C);
   endtask

   task automatic t_bits();
      logic [7:0] v;
      v = 8'h00;
      wr_reg(fa(7'h12), 32'h00);
      wr_reg(ABE_OFF_FLAGS, 32'h5);
      for (int b = 0; b < 8; b++) begin
         v[b] = 1'b1;
         exec(ABE_OP_SET_BIT, {b[2:0], 7'h12});
         rd_chk(fa(7'h12), {24'h0, v});
      end
      for (int b = 7; b >= 0; b -= 2) begin
         v[b] = 1'b0;
         exec(ABE_OP_CLR_BIT, {b[2:0], 7'h12});
         rd_chk(fa(7'h12), {24'h0, v});
      end
      rd_chk(ABE_OFF_FLAGS, 32'h5);
   endtask

   // Discarded slot must still be counted; the cycle count shows the second cycle, the unchanged accumulator and flags show it did nothing
   task automatic t_skip();
      logic [31:0] c0;
      wr_reg(fa(7'h13), 32'h02);
      wr_reg(ABE_OFF_ACC, 32'h00);
      wr_reg(ABE_OFF_FLAGS, 32'h0);
      bus(1'b0, ABE_OFF_CYCLES, 32'h0, 4'hF, c0);
      exec(ABE_OP_TEST_SKIP, {3'd0, 7'h13});
      rd_chk(ABE_OFF_FLAGS, 32'h8);
      exec(ABE_OP_ADD_LIT, 10'h005);
      rd_chk(ABE_OFF_ACC, 32'h00);
      rd_chk(ABE_OFF_FLAGS, 32'h0);
      rd_chk(ABE_OFF_CYCLES, c0 + 32'd2);
      exec(ABE_OP_TEST_SKIP, {3'd1, 7'h13});
      rd_chk(ABE_OFF_FLAGS, 32'h0);
      exec(ABE_OP_ADD_LIT, 10'h005);
      rd_chk(ABE_OFF_ACC, 32'h05);
      rd_chk(ABE_OFF_CYCLES, c0 + 32'd4);
   endtask

   task automatic t_port();
      @(posedge clk_sys);
      pins_in <= 8'h5A;
      rd_chk(fa(ABE_PORT_ADDR), 32'h5A);
      exec(ABE_OP_SET_BIT, {3'd0, ABE_PORT_ADDR});
      chk({24'h0, port_out}, 32'h5B);
      @(posedge clk_sys);
      pins_in <= 8'h0F;
      exec(ABE_OP_CLR_BIT, {3'd0, ABE_PORT_ADDR});
      chk({24'h0, port_out}, 32'h0E);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 20000);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_lanes();
      t_add_lit();
      t_add_file();
      t_and();
      t_bits();
      t_skip();
      t_mid_reset();
      t_port();
      tally_and_finish();
   end
endmodule // tb_acc_logic_bit_op_exec

// *** verilog/abe_alu.sv ***
/*
 Eight-bit adder and AND unit with carry, digit-carry and zero outputs.
 Assumes the caller picks which flags to keep; this unit always computes all three.
*/
`timescale 1ns/1ns
module abe_alu (
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic do_and,
   output abe_pkg::abe_alu_out_t out
);
   import abe_pkg::*;

   logic [4:0] lo;
   logic [8:0] sum;
   logic [7:0] res;

   always_comb begin
      lo = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
      sum = {1'b0, acc} + {1'b0, opnd};
      res = do_and ? (acc & opnd) : sum[7:0];
      out.res = res;
      out.c = sum[8];
      out.dc = lo[4];
      out.z = (res == 8'h00);
   end

endmodule // abe_alu

// *** verilog/abe_core.sv ***
/*
 Executor for add, AND and bit instructions on the accumulator and file registers, behind an Avalon-MM slave.
 Assumes the master holds each request until waitrequest is low and never reads and writes together.
*/
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module abe_core (
   input wire logic clk_sys,
   input wire logic resetn,
   input abe_pkg::abe_avm_req_t avm_req,
   output abe_pkg::abe_avm_rsp_t avm_rsp,
   input wire logic [7:0] pins_in,
   output logic [7:0] port_out
);
   import abe_pkg::*;

   abe_core_st_t s;
   abe_core_st_t n;
   abe_fwr_t fwr;
   abe_alu_out_t alu_o;
   logic rsp_wait;
   logic [3:0] op_w;
   logic [6:0] f_w;
   logic [2:0] b_w;
   logic d_w;
   logic [7:0] k_w;
   logic [7:0] fdat;
   logic [6:0] rd_addr;
   logic lit_w;
   logic and_w;
   logic [7:0] bmask;
   logic [31:0] bus_rd;
   logic [31:0] merged;
   logic run;

   ////////////////////////////////////////////////////////////////////////////
   assign op_w = s.instr[ABE_OP_LSB +: 4];
   assign f_w = s.instr[6:0];
   assign b_w = s.instr[ABE_B_LSB +: 3];
   assign d_w = s.instr[ABE_D_BIT];
   assign k_w = s.instr[7:0];
   assign lit_w = (op_w == ABE_OP_ADD_LIT) || (op_w == ABE_OP_AND_LIT);
   assign and_w = (op_w == ABE_OP_AND_LIT) || (op_w == ABE_OP_AND_FILE);
   assign bmask = 8'h01 << b_w;
   assign run = (s.st == ABE_EXEC) && !s.skip;
   assign rd_addr = (s.st == ABE_EXEC) ? f_w : avm_req.address[8:2];

   abe_file_regs #(
      .DEPTH(128)
   ) u_file (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rd_addr(rd_addr),
      .rd_data(fdat),
      .wr(fwr),
      .pins_in(pins_in),
      .port_out(port_out)
   );

   abe_alu u_alu (
      .acc(s.acc),
      .opnd(lit_w ? k_w : fdat),
      .do_and(and_w),
      .out(alu_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      bus_rd = 32'h00000000;
      if (abe_is_file(avm_req.address)) begin
         bus_rd = {24'h000000, fdat};
      end else begin
         case (avm_req.address)
            ABE_OFF_INSTR: bus_rd = {18'h00000, s.instr};
            ABE_OFF_ACC: bus_rd = {24'h000000, s.acc};
            ABE_OFF_FLAGS: bus_rd = {28'h0000000, s.skip, s.z, s.dc, s.c};
            ABE_OFF_CYCLES: bus_rd = {16'h0000, s.cycles};
            default: bus_rd = 32'h00000000;
         endcase
      end
   end

   assign merged = abe_merge(bus_rd, avm_req.writedata, avm_req.byteenable);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      fwr = '0;
      rsp_wait = 1'b1;
      case (s.st)
         ABE_IDLE: begin
            if (avm_req.write && avm_req.address == ABE_OFF_INSTR) begin
               n.instr = merged[13:0];
               n.st = ABE_EXEC;
            end else if (avm_req.read || avm_req.write) begin
               n.rdata = bus_rd;
               n.st = ABE_RESP;
            end
         end
         ABE_EXEC: begin
            n.st = ABE_RESP;
            n.cycles = s.cycles + 16'h0001;
            if (s.skip) begin
               // Discarded instruction burns its cycle as a no-op
               n.skip = 1'b0;
            end else begin
               case (op_w)
                  ABE_OP_ADD_LIT: begin
                     n.acc = alu_o.res;
                     n.c = alu_o.c;
                     n.dc = alu_o.dc;
                     n.z = alu_o.z;
                  end
                  ABE_OP_ADD_FILE, ABE_OP_AND_FILE: begin
                     if (d_w) begin
                        fwr = '{we: 1'b1, addr: f_w, data: alu_o.res};
                     end else begin
                        n.acc = alu_o.res;
                     end
                     n.z = alu_o.z;
                     if (op_w == ABE_OP_ADD_FILE) begin
                        n.c = alu_o.c;
                        n.dc = alu_o.dc;
                     end
                  end
                  ABE_OP_AND_LIT: begin
                     n.acc = alu_o.res;
                     n.z = alu_o.z;
                  end
                  ABE_OP_CLR_BIT: fwr = '{we: 1'b1, addr: f_w, data: fdat & ~bmask};
                  ABE_OP_SET_BIT: fwr = '{we: 1'b1, addr: f_w, data: fdat | bmask};
                  ABE_OP_TEST_SKIP: n.skip = ((fdat & bmask) == 8'h00);
                  default: n.skip = 1'b0;
               endcase
            end
         end
         ABE_RESP: begin
            rsp_wait = 1'b0;
            n.st = ABE_IDLE;
            if (avm_req.write) begin
               if (abe_is_file(avm_req.address)) begin
                  fwr = '{we: 1'b1, addr: avm_req.address[8:2], data: merged[7:0]};
               end else if (avm_req.address == ABE_OFF_ACC) begin
                  n.acc = merged[7:0];
               end else if (avm_req.address == ABE_OFF_FLAGS) begin
                  n.c = merged[ABE_FLG_C];
                  n.dc = merged[ABE_FLG_DC];
                  n.z = merged[ABE_FLG_Z];
               end
            end
         end
         default: n = ABE_CORE_RST;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s <= ABE_CORE_RST;
      end else begin
         s <= n;
      end
   end

   assign avm_rsp = '{readdata: s.rdata, waitrequest: rsp_wait};

   ////////////////////////////////////////////////////////////////////////////
   logic [8:0] sum9;
   logic [4:0] sum5;
   assign sum9 = {1'b0, s.acc} + {1'b0, fdat};
   assign sum5 = {1'b0, s.acc[3:0]} + {1'b0, fdat[3:0]};

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   add_lit_acc_a: assert property (
      run && op_w == ABE_OP_ADD_LIT |=> s.acc == 8'($past(s.acc) + $past(k_w)))
      else $error("add literal gave wrong accumulator");

   add_file_flags_a: assert property (
      run && op_w == ABE_OP_ADD_FILE |=> s.c == $past(sum9[8]) && s.dc == $past(sum5[4]))
      else $error("add file gave wrong carry flags");

   dest_select_a: assert property (
      run && (op_w == ABE_OP_ADD_FILE || op_w == ABE_OP_AND_FILE)
      |-> (fwr.we == d_w) && (d_w ? 1'b1 : (n.acc == alu_o.res)))
      else $error("destination select misrouted result");

   and_lit_flags_a: assert property (
      run && op_w == ABE_OP_AND_LIT
      |=> s.acc == ($past(s.acc) & $past(k_w)) && $stable(s.c) && $stable(s.dc))
      else $error("and literal wrong or touched carry");

   and_file_flags_a: assert property (
      run && op_w == ABE_OP_AND_FILE
      |=> $stable(s.c) && $stable(s.dc) && s.z == (($past(s.acc) & $past(fdat)) == 8'h00))
      else $error("and file touched carry flags");

   clear_bit_a: assert property (
      run && op_w == ABE_OP_CLR_BIT
      |-> fwr.we && fwr.data[b_w] == 1'b0 ##1 $stable(s.z) && $stable(s.c) && $stable(s.dc))
      else $error("clear bit failed or changed flags");

   set_bit_a: assert property (
      run && op_w == ABE_OP_SET_BIT
      |-> fwr.we && fwr.data[b_w] && (fwr.data | bmask) == (fdat | bmask) ##1 $stable(s.z))
      else $error("set bit failed or changed flags");

   skip_taken_a: assert property (
      run && op_w == ABE_OP_TEST_SKIP |=> s.skip == !$past(fdat[b_w]))
      else $error("skip decision wrong");

   skip_nop_a: assert property (
      s.st == ABE_EXEC && s.skip |-> !fwr.we ##1 !s.skip && $stable(s.acc) && $stable(s.z))
      else $error("discarded instruction had an effect");

   zero_flag_a: assert property (
      run && op_w == ABE_OP_ADD_LIT
      |=> s.z == (s.acc == 8'h00) && {s.c, s.acc} == 9'($past({1'b0, s.acc}) + $past({1'b0, k_w})))
      else $error("zero or carry flag wrong");

   port_pins_a: assert property (
      run && op_w == ABE_OP_SET_BIT && f_w == ABE_PORT_ADDR |-> fwr.data == (pins_in | bmask))
      else $error("port write back did not use pins");

   instr_latency_a: assert property (
      s.st == ABE_IDLE && avm_req.write && avm_req.address == ABE_OFF_INSTR
      |-> rsp_wait ##1 rsp_wait ##1 !rsp_wait)
      else $error("instruction write latency wrong");

   add_file_acc_a: assert property (
      run && op_w == ABE_OP_ADD_FILE && !d_w |=> s.acc == 8'($past(s.acc) + $past(fdat)))
      else $error("add file gave wrong accumulator");

   file_dest_data_a: assert property (
      run && op_w == ABE_OP_ADD_FILE && d_w
      |-> fwr.addr == f_w && fwr.data == 8'(s.acc + fdat) ##1 $stable(s.acc))
      else $error("file destination got wrong data");

   and_file_acc_a: assert property (
      run && op_w == ABE_OP_AND_FILE && !d_w |=> s.acc == ($past(s.acc) & $past(fdat)))
      else $error("and file gave wrong accumulator");

   clear_keep_a: assert property (
      run && op_w == ABE_OP_CLR_BIT |-> fwr.addr == f_w && (fwr.data | bmask) == (fdat | bmask))
      else $error("clear bit disturbed other bits");

   test_no_effect_a: assert property (
      run && op_w == ABE_OP_TEST_SKIP
      |-> !fwr.we ##1 $stable(s.acc) && $stable(s.c) && $stable(s.dc) && $stable(s.z))
      else $error("bit test changed state");

   cycle_count_a: assert property (
      s.st == ABE_EXEC |=> s.cycles == 16'($past(s.cycles) + 16'h0001))
      else $error("executed cycle not counted");

   digit_carry_a: assert property (
      run && op_w == ABE_OP_ADD_LIT
      |=> s.dc == (5'($past({1'b0, s.acc[3:0]}) + $past({1'b0, k_w[3:0]})) > 5'h0F))
      else $error("digit carry wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Bus side: the master waits on these timings, so they are checked apart from the rules
   reset_values_a: assert property (
      $rose(resetn) |-> s.acc == ABE_ACC_RST && !s.skip && !s.z && s.cycles == ABE_CYCLES_RST
      && rsp_wait && port_out == ABE_PORT_RST)
      else $error("state after reset wrong");

   plain_latency_a: assert property (
      s.st == ABE_IDLE && (avm_req.read || avm_req.write) && avm_req.address != ABE_OFF_INSTR
      |-> rsp_wait ##1 !rsp_wait)
      else $error("plain access latency wrong");

   resp_one_cycle_a: assert property (
      !rsp_wait |=> rsp_wait)
      else $error("response stood too long");

   acc_read_a: assert property (
      s.st == ABE_IDLE && avm_req.read && avm_req.address == ABE_OFF_ACC
      |=> avm_rsp.readdata == {24'h000000, $past(s.acc)})
      else $error("accumulator read wrong");

   acc_write_a: assert property (
      s.st == ABE_RESP && avm_req.write && avm_req.address == ABE_OFF_ACC && avm_req.byteenable[0]
      |=> s.acc == $past(avm_req.writedata[7:0]))
      else $error("accumulator write lost");

   idle_no_write_a: assert property (
      s.st == ABE_IDLE |-> !fwr.we)
      else $error("file written while idle");

   file_bus_write_a: assert property (
      s.st == ABE_RESP && avm_req.write && abe_is_file(avm_req.address) && avm_req.byteenable[0]
      |-> fwr.we && fwr.addr == avm_req.address[8:2] && fwr.data == avm_req.writedata[7:0])
      else $error("bus write to file register lost");

   instr_capture_a: assert property (
      s.st == ABE_IDLE && avm_req.write && avm_req.address == ABE_OFF_INSTR && avm_req.byteenable[1:0] == 2'h3
      |=> s.instr == $past(avm_req.writedata[13:0]))
      else $error("instruction not captured");

   skip_cov_c: cover property (run && op_w == ABE_OP_TEST_SKIP ##1 s.skip ##[1:20] s.st == ABE_EXEC);
   carry_cov_c: cover property (run && op_w == ABE_OP_ADD_FILE && alu_o.c && !d_w);
   and_dest_cov_c: cover property (run && op_w == ABE_OP_AND_FILE && d_w);
   port_cov_c: cover property (run && f_w == ABE_PORT_ADDR && op_w == ABE_OP_CLR_BIT);
   read_cov_c: cover property (s.st == ABE_RESP && avm_req.read);

endmodule // abe_core

// *** verilog/abe_file_regs.sv ***
/*
 File register array with one port register whose reads return the pin levels.
 Assumes pins are synchronous to clk_sys; one write and one read address per cycle.
*/
`timescale 1ns/1ns
module abe_file_regs #(
   parameter int DEPTH = 128
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input abe_pkg::abe_fwr_t wr,
   input wire logic [7:0] pins_in,
   output logic [7:0] port_out
);
   import abe_pkg::*;

   logic [7:0] mem [DEPTH];
   logic [7:0] port_r;

   // Array left unreset: software must initialise what it uses
   always_ff @(posedge clk_sys) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_r <= ABE_PORT_RST;
      end else if (wr.we && wr.addr == ABE_PORT_ADDR) begin
         port_r <= wr.data;
      end
   end

   // A pin held low by the outside clears its latch bit on any bit set, bit clear or AND write back
   assign rd_data = (rd_addr == ABE_PORT_ADDR) ? pins_in : mem[rd_addr];
   assign port_out = port_r;

endmodule // abe_file_regs
